/* core/metering_channel_front_filter.sv */
// Purpose: voltage and current digital front end after the modulators
// Assumes: pclk is the master clock; modulator bits are synchronous
// Notes: apb slave, zero wait states, error on unmapped or read-only write
//
// The register addresses and register access over APB were decided locally.
module metering_channel_front_filter (
   input wire logic pclk, // master clock
   input wire logic presetn, // async reset, active low
   input wire logic v_mod_bit, // voltage modulator bit
   input wire logic i_mod_bit, // current modulator bit
   output logic mod_sample_stb, // modulator sample strobe
   output logic word_valid, // pulse: new corrected words
   output logic signed [23:0] v_word, // corrected voltage sample
   output logic signed [23:0] i_word, // corrected current sample
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr // apb error
);
   function automatic logic signed [23:0] sat24(input logic signed [49:0] x);
      if (x > 50'sd8388607) begin
         return 24'sh7fffff;
      end else if (x < -50'sd8388608) begin
         return 24'sh800000;
      end
      return x[23:0];
   endfunction

   // ---------------- registers
   front_filter_pkg::setup_t setup_ff;
   front_filter_pkg::phase_delay_t phase_ff;
   front_filter_pkg::trim_t trim_ff [2];
   logic [2:0] mod_cnt_ff;
   logic [31:0] nxt_prdata;
   logic [31:0] prdata_ff;
   logic wr, rd_setup, mapped, ro_hit;

   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign mapped = paddr inside {front_filter_pkg::REG_SETUP2,
      front_filter_pkg::REG_PHASE, front_filter_pkg::REG_V_OFF,
      front_filter_pkg::REG_V_GAIN, front_filter_pkg::REG_I_OFF,
      front_filter_pkg::REG_I_GAIN, front_filter_pkg::REG_V_DATA,
      front_filter_pkg::REG_I_DATA};
   assign ro_hit = paddr == front_filter_pkg::REG_V_DATA ||
      paddr == front_filter_pkg::REG_I_DATA;
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));
   assign prdata = prdata_ff;

   always_comb begin
      nxt_prdata = 32'h00000000;
      unique case (paddr)
         front_filter_pkg::REG_SETUP2: nxt_prdata = {29'h0, setup_ff};
         front_filter_pkg::REG_PHASE: nxt_prdata = {21'h0, phase_ff};
         front_filter_pkg::REG_V_OFF: nxt_prdata = {8'h00, trim_ff[0].offset};
         front_filter_pkg::REG_V_GAIN: nxt_prdata = {8'h00, trim_ff[0].gain};
         front_filter_pkg::REG_I_OFF: nxt_prdata = {8'h00, trim_ff[1].offset};
         front_filter_pkg::REG_I_GAIN: nxt_prdata = {8'h00, trim_ff[1].gain};
         front_filter_pkg::REG_V_DATA: nxt_prdata = {8'h00, v_word};
         front_filter_pkg::REG_I_DATA: nxt_prdata = {8'h00, i_word};
         default: nxt_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_ff <= front_filter_pkg::SETUP2_RST;
         phase_ff <= front_filter_pkg::PHASE_RST;
         for (int c = 0; c < 2; c++) begin
            trim_ff[c].offset <= front_filter_pkg::OFF_RST;
            trim_ff[c].gain <= front_filter_pkg::GAIN_RST;
         end
         prdata_ff <= 32'h00000000;
      end else begin
         if (rd_setup && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end
         if (wr) begin
            unique case (paddr)
               front_filter_pkg::REG_SETUP2: setup_ff <= pwdata[2:0];
               front_filter_pkg::REG_PHASE: phase_ff <= pwdata[10:0];
               front_filter_pkg::REG_V_OFF: trim_ff[0].offset <= pwdata[23:0];
               front_filter_pkg::REG_V_GAIN: trim_ff[0].gain <= pwdata[23:0];
               front_filter_pkg::REG_I_OFF: trim_ff[1].offset <= pwdata[23:0];
               front_filter_pkg::REG_I_GAIN: trim_ff[1].gain <= pwdata[23:0];
               default: ;
            endcase
         end
      end
   end

   // ---------------- modulator sampling and decimation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_cnt_ff <= 3'h0;
      end else begin
         mod_cnt_ff <= mod_cnt_ff + 3'h1;
      end
   end
   assign mod_sample_stb = mod_cnt_ff == front_filter_pkg::MOD_CNT_LAST;

   logic dec_valid, i_dec_valid;
   logic signed [23:0] v_dec, i_dec;

   // both decimators share one strobe so their words stay aligned
   sinc3_decimator u_v_dec (
      .pclk(pclk),
      .presetn(presetn),
      .sample_stb(mod_sample_stb),
      .bit_in(v_mod_bit),
      .word_valid(dec_valid),
      .word(v_dec)
   );
   sinc3_decimator u_i_dec (
      .pclk(pclk),
      .presetn(presetn),
      .sample_stb(mod_sample_stb),
      .bit_in(i_mod_bit),
      .word_valid(i_dec_valid),
      .word(i_dec)
   );

   // ---------------- phase compensation
   // word history: [0] newest; voltage and current both keep three words
   logic signed [23:0] vh_ff [3];
   logic signed [23:0] ih_ff [3];
   logic [1:0] v_sel;
   logic i_sel;
   logic signed [23:0] ia, ib, v_dly;
   logic signed [34:0] i_frac;
   logic signed [23:0] i_dly;

   assign v_sel = (phase_ff.coarse_phase_delay > 2'h2) ? 2'h2 :
      phase_ff.coarse_phase_delay;
   assign i_sel = phase_ff.coarse_phase_delay[1];
   assign v_dly = vh_ff[v_sel];
   assign ia = i_sel ? ih_ff[1] : ih_ff[0];
   assign ib = i_sel ? ih_ff[2] : ih_ff[1];
   // linear interpolation toward the older word, 1/512 word per step
   assign i_frac = (35'(ib) - 35'(ia)) *
      $signed({26'h0, phase_ff.fine_phase_delay});
   assign i_dly = sat24(50'(ia) + 50'(i_frac >>> front_filter_pkg::FINE_W));
   // a current delay longer than the voltage one lags the voltage

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 3; k++) begin
            vh_ff[k] <= 24'sh000000;
            ih_ff[k] <= 24'sh000000;
         end
      end else if (dec_valid) begin
         vh_ff[0] <= v_dec;
         ih_ff[0] <= i_dec;
         vh_ff[1] <= vh_ff[0];
         ih_ff[1] <= ih_ff[0];
         vh_ff[2] <= vh_ff[1];
         ih_ff[2] <= ih_ff[1];
      end
   end

   // ---------------- per-channel droop, high-pass, trim
   logic d1_ff, d2_ff, d3_ff, d4_ff;
   logic signed [23:0] s1 [2];
   logic signed [23:0] s2_ff [2];
   logic signed [23:0] s3_ff [2];
   logic signed [23:0] out_ff [2];
   logic hpf_en [2];

   assign s1[0] = v_dly;
   assign s1[1] = i_dly;
   assign hpf_en[0] = setup_ff.hpf_v_en;
   assign hpf_en[1] = setup_ff.hpf_i_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d1_ff <= 1'b0;
         d2_ff <= 1'b0;
         d3_ff <= 1'b0;
         d4_ff <= 1'b0;
      end else begin
         d1_ff <= dec_valid;
         d2_ff <= d1_ff;
         d3_ff <= d2_ff;
         d4_ff <= d3_ff;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic signed [23:0] y_droop_ff, x_hp_ff;
      logic signed [31:0] y_hp_ff;
      logic signed [31:0] nxt_droop, nxt_hp;
      logic signed [47:0] hp_leak;
      logic signed [49:0] trimmed;

      // unity at dc, 9/7 at nyquist; lifts the sinc droop across the band
      assign nxt_droop = 32'(s1[c]) +
         ((32'(s1[c]) - 32'(y_droop_ff)) >>> front_filter_pkg::DROOP_SHIFT);
      // one-pole dc blocker: y = x - x1 + y1 - a*y1
      assign hp_leak = 48'(y_hp_ff) * 48'(front_filter_pkg::HPF_COEF);
      assign nxt_hp = 32'(s2_ff[c]) - 32'(x_hp_ff) + y_hp_ff -
         32'(hp_leak >>> front_filter_pkg::HPF_FRAC);
      assign trimmed = ((50'(s3_ff[c]) + 50'(trim_ff[c].offset)) *
         $signed({26'h0, trim_ff[c].gain})) >>>
         front_filter_pkg::GAIN_FRAC;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            y_droop_ff <= 24'sh000000;
            x_hp_ff <= 24'sh000000;
            y_hp_ff <= 32'sh00000000;
            s2_ff[c] <= 24'sh000000;
            s3_ff[c] <= 24'sh000000;
            out_ff[c] <= 24'sh000000;
         end else begin
            if (d1_ff) begin
               y_droop_ff <= sat24(50'(nxt_droop));
               s2_ff[c] <= setup_ff.droop_stage_bypass ? s1[c] :
                  sat24(50'(nxt_droop));
            end
            if (d2_ff) begin
               x_hp_ff <= s2_ff[c];
               y_hp_ff <= nxt_hp;
               s3_ff[c] <= hpf_en[c] ? sat24(50'(nxt_hp)) : s2_ff[c];
            end
            if (d3_ff) begin
               out_ff[c] <= sat24(trimmed);
            end
         end
      end
   end

   assign v_word = out_ff[0];
   assign i_word = out_ff[1];
   assign word_valid = d4_ff;

   // ---------------- checks
   logic [9:0] gap_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff <= 10'h000;
      end else begin
         gap_ff <= dec_valid ? 10'h000 : gap_ff + 10'h001;
      end
   end

   sample_stride_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      mod_sample_stb |=> !mod_sample_stb [*7] ##1 mod_sample_stb)
      else $error("modulator strobe not every 8 clocks");

   word_period_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      dec_valid && $past(dec_valid, 1) == 1'b0 && gap_ff != 10'h000
      |-> gap_ff == front_filter_pkg::WORD_GAP)
      else $error("decimated word period not 1024 clocks");

   channels_aligned_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      dec_valid == i_dec_valid)
      else $error("channel decimators out of step");

   droop_default_a: assert property (
      @(posedge pclk) $rose(presetn) |-> !setup_ff.droop_stage_bypass)
      else $error("droop stage not active after reset");

   bypass_pass_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      d1_ff && setup_ff.droop_stage_bypass |=> s2_ff[1] == $past(i_dly))
      else $error("bypass altered the sample");

   fine_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff == 11'h000 |-> i_dly == ih_ff[0])
      else $error("zero delay moved the current word");

   volt_coarse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay == 2'h2 |-> v_dly == vh_ff[2])
      else $error("voltage coarse delay not two words");

   hpf_off_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      d2_ff && !setup_ff.hpf_v_en |=> s3_ff[0] == $past(s2_ff[0]))
      else $error("disabled high-pass changed the sample");

   unity_trim_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      d3_ff && trim_ff[0].gain == front_filter_pkg::GAIN_RST &&
      trim_ff[0].offset == 24'sh000000
      |=> word_valid && v_word == $past(s3_ff[0]))
      else $error("unity trim changed the voltage sample");

   volt_coarse_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay == 2'h0 |-> v_dly == vh_ff[0])
      else $error("voltage moved with coarse delay zero");

   volt_coarse_one_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay == 2'h1 |-> v_dly == vh_ff[1])
      else $error("voltage coarse delay not one word");

   cur_coarse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay[1] &&
      phase_ff.fine_phase_delay == 9'h000 |-> i_dly == ih_ff[1])
      else $error("current coarse delay not one word");

   volt_lead_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay == 2'h0 &&
      phase_ff.fine_phase_delay != 9'h000
      |-> v_dly == vh_ff[0] && ia == ih_ff[0] && ib == ih_ff[1])
      else $error("fine delay not applied to current only");

   fine_flat_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      phase_ff.coarse_phase_delay == 2'h0 && ih_ff[0] == ih_ff[1]
      |-> i_dly == ih_ff[0])
      else $error("interpolation between equal words moved");

   volt_bypass_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      d1_ff && setup_ff.droop_stage_bypass |=> s2_ff[0] == $past(v_dly))
      else $error("bypass altered the voltage sample");

   cur_sat_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      d3_ff && trim_ff[1].gain == front_filter_pkg::GAIN_RST &&
      s3_ff[1] == 24'sh7fffff && !trim_ff[1].offset[23]
      |=> i_word == 24'sh7fffff)
      else $error("positive overflow not saturated");

   word_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      word_valid |=> !word_valid)
      else $error("word pulse longer than one clock");
endmodule

/* core/front_filter_pkg.sv */
// Purpose: shared constants and carriers of the metering channel filter
// Assumes: 24-bit signed sample words, one word per 1024 master clocks
// Notes: register map is word aligned on a 32-bit apb bus
package front_filter_pkg;
   localparam int DATA_W = 24;
   localparam int MOD_DIV = 8;
   localparam int WORD_DIV = 1024;
   localparam int DEC_RATIO = WORD_DIV / MOD_DIV;
   localparam int SINC_W = 22;
   localparam int FINE_W = 9;
   localparam int COARSE_W = 2;
   localparam int DROOP_SHIFT = 3;
   localparam int GAIN_FRAC = 22;
   localparam int HPF_FRAC = 16;
   localparam real MCLK_NOM_HZ = 4096000.0;
   localparam real NYQUIST_HZ = 2000.0;
   localparam real HPF_CORNER_HZ = 2.0;
   localparam real PI = 3.14159265358979;
   // coefficient fixed for the nominal master clock
   localparam int HPF_COEF = int'(2.0 * PI * HPF_CORNER_HZ * WORD_DIV
      / MCLK_NOM_HZ * 65536.0);
   localparam logic [7:0] REG_SETUP2 = 8'h00;
   localparam logic [7:0] REG_PHASE = 8'h04;
   localparam logic [7:0] REG_V_OFF = 8'h08;
   localparam logic [7:0] REG_V_GAIN = 8'h0c;
   localparam logic [7:0] REG_I_OFF = 8'h10;
   localparam logic [7:0] REG_I_GAIN = 8'h14;
   localparam logic [7:0] REG_V_DATA = 8'h18;
   localparam logic [7:0] REG_I_DATA = 8'h1c;
   localparam logic [2:0] SETUP2_RST = 3'h0;
   localparam logic [10:0] PHASE_RST = 11'h000;
   localparam logic [23:0] OFF_RST = 24'h000000;
   localparam logic [23:0] GAIN_RST = 24'h400000;
   localparam logic [2:0] MOD_CNT_LAST = 3'h7;
   localparam logic [6:0] DEC_CNT_LAST = 7'h7f;
   localparam logic [9:0] WORD_GAP = 10'h3ff;
   typedef struct packed {
      logic droop_stage_bypass;
      logic hpf_i_en;
      logic hpf_v_en;
   } setup_t;
   typedef struct packed {
      logic [1:0] coarse_phase_delay;
      logic [8:0] fine_phase_delay;
   } phase_delay_t;
   typedef struct packed {
      logic signed [23:0] offset;
      logic [23:0] gain;
   } trim_t;
endpackage

/* core/sinc3_decimator.sv */
// Purpose: third-order sinc decimator, one bit in, 24-bit word out
// Assumes: sample_stb pulses once every 8 clocks
// Notes: integrators wrap on purpose; the combs undo the wrap
module sinc3_decimator (
   input wire logic pclk, // master clock
   input wire logic presetn, // async reset, active low
   input wire logic sample_stb, // modulator sample instant
   input wire logic bit_in, // modulator bit
   output logic word_valid, // one-cycle pulse per word
   output logic signed [23:0] word // decimated word
);
   localparam int W = front_filter_pkg::SINC_W;
   logic [6:0] dec_ff;
   logic [W-1:0] int1_ff, int2_ff, int3_ff;
   logic [W-1:0] c1_ff, c2_ff, c3_ff;
   logic [W-1:0] d1, d2, d3;
   logic dump;
   logic signed [26:0] scaled;

   assign dump = sample_stb && dec_ff == front_filter_pkg::DEC_CNT_LAST;
   assign d1 = int3_ff - c1_ff;
   assign d2 = d1 - c2_ff;
   assign d3 = d2 - c3_ff;
   // unipolar count 0..2^21 mapped to a signed word
   assign scaled = $signed({5'h00, d3}) * 27'sd8 - 27'sd8388608;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_ff <= 7'h00;
         int1_ff <= '0;
         int2_ff <= '0;
         int3_ff <= '0;
         c1_ff <= '0;
         c2_ff <= '0;
         c3_ff <= '0;
         word_valid <= 1'b0;
         word <= 24'sh000000;
      end else begin
         word_valid <= dump;
         if (sample_stb) begin
            dec_ff <= dec_ff + 7'h01;
            int1_ff <= int1_ff + {{(W-1){1'b0}}, bit_in};
            int2_ff <= int2_ff + int1_ff;
            int3_ff <= int3_ff + int2_ff;
         end
         if (dump) begin
            c1_ff <= int3_ff;
            c2_ff <= d1;
            c3_ff <= d2;
            word <= (scaled > 27'sd8388607) ? 24'sh7fffff : scaled[23:0];
         end
      end
   end
endmodule

/* tb/mod_bit_source.sv */
// Purpose: stands in for the voltage and current modulators
// Assumes: mode 0 gives zeros, 1 gives ones, 2 gives alternating bits
// Notes: bits move only after a sampling edge, so no sample sees a change
module mod_bit_source (
   input wire logic pclk, // master clock
   input wire logic presetn, // async reset, active low
   input wire logic sample_stb, // sample strobe from the block
   input wire logic [1:0] v_mode, // voltage pattern
   input wire logic [1:0] i_mode, // current pattern
   output logic v_bit, // voltage modulator bit
   output logic i_bit // current modulator bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phase_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 1'h0;
      end else if (sample_stb) begin
         phase_ff <= ~phase_ff;
      end
   end
   // an even-length sinc window sees as many odd as even bits: mean is zero
   assign v_bit = (v_mode == 2'h2) ? phase_ff : v_mode[0];
   assign i_bit = (i_mode == 2'h2) ? phase_ff : i_mode[0];
endmodule

/* tb/metering_channel_front_filter_tb_top.sv */
// Purpose: self-checking bench for the metering channel front filter
// Assumes: apb answers in the first access cycle; bits come from the model
// Notes: step runs use droop bypass where word values must be exact
module metering_channel_front_filter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic v_mod_bit, i_mod_bit, mod_sample_stb, word_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [23:0] v_word, i_word;
   logic [1:0] v_mode, i_mode;
   int err_count, total_checks;
   metering_channel_front_filter metering_channel_front_filter_i (
      .pclk(pclk), .presetn(presetn), .v_mod_bit(v_mod_bit),
      .i_mod_bit(i_mod_bit), .mod_sample_stb(mod_sample_stb),
      .word_valid(word_valid), .v_word(v_word), .i_word(i_word),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   mod_bit_source mod_bit_source_i (
      .pclk(pclk), .presetn(presetn), .sample_stb(mod_sample_stb),
      .v_mode(v_mode), .i_mode(i_mode), .v_bit(v_mod_bit),
      .i_bit(i_mod_bit));
   initial begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb_xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      // the master allows wait states: it holds until ready is seen
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_word();
      int n;
      n = 0;
      @(posedge pclk);
      #1;
      while (word_valid !== 1'h1 && n < 1100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (n >= 1100) begin
         err_count++;
         $display("FAIL at %0t got %h expected %h", $time, n, 1024);
      end
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge pclk);
      v_mode <= m;
      i_mode <= m;
   endtask
   task automatic measure_gap(input logic is_word, output int n);
      n = 0;
      do @(posedge pclk); while ((is_word ? word_valid : mod_sample_stb)
         !== 1'h1);
      do begin
         @(posedge pclk);
         n++;
      end while ((is_word ? word_valid : mod_sample_stb) !== 1'h1 &&
         n < 2000);
   endtask
   task automatic test_regs();
      logic [31:0] e[6];
      e = '{32'h0, 32'h0, 32'h0, 32'h400000, 32'h0, 32'h400000};
      for (int k = 0; k < 6; k++) begin
         apb_xfer(1'h0, 8'(4 * k), 32'h0);
         check(rd, e[k]);
      end
      apb_xfer(1'h1, front_filter_pkg::REG_PHASE, 32'hffffffff);
      apb_xfer(1'h0, front_filter_pkg::REG_PHASE, 32'h0);
      check(rd, 32'h7ff);
      apb_xfer(1'h1, front_filter_pkg::REG_PHASE, 32'h0);
      apb_xfer(1'h0, 8'h40, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      apb_xfer(1'h1, front_filter_pkg::REG_V_DATA, 32'h1234);
      check({31'h0, er}, 32'h1);
   endtask
   task automatic test_timing();
      int n;
      measure_gap(1'h0, n);
      check(n, 8);
      measure_gap(1'h1, n);
      check(n, 1024);
   endtask
   // step from zeros to alternating bits; index of first zero word per lane
   task automatic step_run(input logic [2:0] s, input logic [10:0] ph,
      output int vi, output int ii, output logic pos);
      apb_xfer(1'h1, front_filter_pkg::REG_SETUP2, {29'h0, s});
      apb_xfer(1'h1, front_filter_pkg::REG_PHASE, {21'h0, ph});
      set_mode(2'h0);
      repeat (6) wait_word();
      set_mode(2'h2);
      vi = 99;
      ii = 199;
      pos = 1'h0;
      for (int k = 0; k < 8; k++) begin
         wait_word();
         if (v_word > 0) begin
            pos = 1'h1;
         end
         if (vi == 99 && v_word === 24'h0) begin
            vi = k;
         end
         if (ii == 199 && i_word === 24'h0) begin
            ii = k;
         end
      end
   endtask
   task automatic test_phase();
      logic [10:0] ph[4];
      int want[4];
      int vi, ii;
      logic pos;
      ph = '{11'h000, 11'h200, 11'h400, 11'h100};
      want = '{0, 1, 1, -1};
      for (int k = 0; k < 4; k++) begin
         step_run(3'h4, ph[k], vi, ii, pos);
         check(vi - ii, want[k]);
         if (k == 0) begin
            check({31'h0, pos}, 32'h0);
         end
      end
   endtask
   task automatic test_droop();
      int vi, ii;
      logic pos;
      // the correction stage boosts a rising step, so it overshoots zero
      step_run(3'h0, 11'h0, vi, ii, pos);
      check({31'h0, pos}, 32'h1);
      check({31'h0, v_word < 64 && v_word > -64}, 32'h1);
   endtask
   task automatic test_trim();
      apb_xfer(1'h1, front_filter_pkg::REG_SETUP2, 32'h4);
      apb_xfer(1'h1, front_filter_pkg::REG_V_GAIN, 32'h200000);
      apb_xfer(1'h1, front_filter_pkg::REG_I_OFF, 32'h100000);
      apb_xfer(1'h1, front_filter_pkg::REG_I_GAIN, 32'h200000);
      set_mode(2'h0);
      repeat (4) wait_word();
      check({8'h0, v_word}, 32'hc00000);
      check({8'h0, i_word}, 32'hc80000);
      apb_xfer(1'h1, front_filter_pkg::REG_V_GAIN, 32'h800000);
      apb_xfer(1'h1, front_filter_pkg::REG_I_GAIN, 32'h400000);
      set_mode(2'h1);
      repeat (4) wait_word();
      check({8'h0, v_word}, 32'h7fffff);
      check({8'h0, i_word}, 32'h7fffff);
      set_mode(2'h0);
      repeat (4) wait_word();
      check({8'h0, v_word}, 32'h800000);
   endtask
   task automatic test_hpf();
      logic signed [23:0] w1, w2;
      apb_xfer(1'h1, front_filter_pkg::REG_V_GAIN, 32'h400000);
      apb_xfer(1'h1, front_filter_pkg::REG_SETUP2, 32'h7);
      set_mode(2'h2);
      repeat (4) wait_word();
      w1 = v_word;
      repeat (2) wait_word();
      w2 = v_word;
      // with a held input the dc blocker only decays toward zero
      check({31'h0, (w1 < 0) ? (w2 >= w1 && w2 <= 0) :
         (w2 <= w1 && w2 >= 0)}, 32'h1);
   endtask
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      v_mode = 2'h2;
      i_mode = 2'h2;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      test_regs();
      test_timing();
      test_phase();
      test_droop();
      test_trim();
      test_hpf();
      complete_run();
   end
   initial begin
      // about 92k cycles of tests; the margin covers a slow word
      repeat (99000) @(posedge pclk);
      err_count++;
      complete_run();
   end
endmodule
